/* smcl_host.sv */
// Host model: shifts command words in and pulses the load strobe
`default_nettype none

module smcl_host (
    input wire logic link_clk_i,   // Timing base, 15 ns
    output logic serial_clock_o,   // Serial clock, still between words
    output logic serial_data_o,    // Serial data
    output logic load_strobe_o     // Load strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serial_clock_o = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk_i);
    endtask

    // Bit period 14 ticks; data flips after hold
    task automatic send_word(input logic [15:0] word);
        for (int i = 15; i >= 0; i--) begin
            serial_data_o <= word[i];
            ticks(7);
            serial_clock_o <= 1'b1;
            ticks(2);
            serial_data_o <= ~word[i];
            ticks(5);
            serial_clock_o <= 1'b0;
        end
        ticks(3);
        load_strobe_o <= 1'b1;
        ticks(8);
        load_strobe_o <= 1'b0;
        ticks(8);
    endtask
endmodule

`default_nettype wire

/* smcl_pkg.sv */
// Constants, types and field layout for the serial motor command latches
// Overview of operation
// - Serial data shifts in on serial clock
// - First bit sent lands in D15, MSB first
// - Strobe falling edge copies sixteen bits to latches
// - Four latch registers of four bits each
// - Latches: phases A, phases B, references, bridge
// - Phase bits drive low sides; conflicting pairs force off
// - Reference codes give 0.125 to 0.500 V
// - Duty bits both set: full drive, no chopping
// - Duty bits both clear: bridge tristated
// - Duty bits 01 low, 10 high chopping
// - Low duty indicator pulled low, else floats
// - Reset pin low: outputs off, registers cleared
// - Same reset during power transitions
// - Oscillator derives two alternating sync clocks
// - Discharge interval blanks the current comparator
// - High side off: recirculation low sides on
`default_nettype none

package smcl_pkg;

    localparam int WORD_W = 16;
    localparam int LATCH_N = 4;
    localparam int LATCH_W = 4;

    // Latch indices within the command word
    localparam int LAT_PHASE_A = 0;
    localparam int LAT_PHASE_B = 1;
    localparam int LAT_REF = 2;
    localparam int LAT_BRIDGE = 3;

    // Field positions inside the reference and bridge latches
    localparam int REF_A_LSB = 0;
    localparam int REF_B_LSB = 2;
    localparam int BR_IN1 = 0;
    localparam int BR_IN2 = 1;
    localparam int BR_DUTY_LO = 2;
    localparam int BR_DUTY_HI = 3;

    // Reference voltage per code step, in millivolts
    localparam logic [9:0] REF_MV_STEP = 10'h07D;

    // Lockout figure and clock rate
    localparam int LOCKOUT_NS = 1400;
    localparam int CLK_MHZ = 100;
    localparam int LOCKOUT_CYC = (LOCKOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int LOCKOUT_CW = $clog2(LOCKOUT_CYC + 1);

    // Synchroniser vector positions
    localparam int PIN_STROBE = 0;
    localparam int PIN_OSC_RST = 1;
    localparam int PIN_POWER = 2;
    localparam int PIN_DISCH = 3;
    localparam int PIN_TRIP_A = 4;
    localparam int PIN_TRIP_B = 5;
    localparam int PIN_PWM = 6;
    localparam int PIN_ACK = 7;
    localparam int PIN_N = 8;

    typedef enum logic [3:0] {
        LEG_OFF = 4'h1,
        LEG_SUPPLY = 4'h2,
        LEG_GROUND = 4'h4,
        LEG_CHOP = 4'h8
    } smcl_leg_state_t;

    // Gate drive for one bridge leg
    typedef struct packed {
        logic high_on;
        logic low_on;
    } smcl_leg_t;

endpackage

`default_nettype wire

/* smcl_props.sv */
// Concurrent checks on the block's output ports
`default_nettype none

module smcl_props (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Synchronous reset
    input wire logic [3:0] stepper_a_out_enable_o, // Channel A low sides
    input wire logic [3:0] stepper_b_out_enable_o, // Channel B low sides
    input wire logic [1:0] stepper_high_side_switch_o, // High sides
    input wire logic [1:0] recirculation_switch_one_o, // Recirculation one
    input wire logic [1:0] recirculation_switch_two_o, // Recirculation two
    input wire logic [1:0] current_ref_a_o, // Reference code A
    input wire logic [1:0] current_ref_b_o, // Reference code B
    input wire logic [9:0] current_ref_a_mv_o, // Reference A in mV
    input wire logic [9:0] current_ref_b_mv_o, // Reference B in mV
    input wire smcl_pkg::smcl_leg_t bridge_out1_o, // Bridge leg one
    input wire smcl_pkg::smcl_leg_t bridge_out2_o, // Bridge leg two
    input wire logic duty_select_voltage_o, // High duty chosen
    input wire logic low_duty_indicator_o, // Open-drain data
    input wire logic low_duty_indicator_oe_o, // Pull-down enable
    input wire logic sync_clock_first_o, // Sync pulse A
    input wire logic sync_clock_second_o, // Sync pulse B
    input wire logic lockout_o, // Blanking active
    input wire logic internal_reset_o // Internal reset
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    function automatic logic clash(input logic [3:0] v);
        return (v[0] & v[1]) | (v[2] & v[3]);
    endfunction

    a_phase_no_clash: assert property (
        !clash(stepper_a_out_enable_o) && !clash(stepper_b_out_enable_o))
        else $error("Low side clash");
    a_ref_mv_match: assert property (
        current_ref_a_mv_o == (current_ref_a_o + 10'h001) * 10'h07D
        && current_ref_b_mv_o == (current_ref_b_o + 10'h001) * 10'h07D)
        else $error("Reference mismatch");
    a_reset_clears: assert property (
        internal_reset_o && $past(internal_reset_o) |-> stepper_a_out_enable_o == 4'h0
        && stepper_high_side_switch_o == 2'h0 && bridge_out1_o == 2'h0
        && current_ref_b_mv_o == 10'h07D)
        else $error("Outputs on in reset");
    a_recirc_inverse: assert property (
        !internal_reset_o && !$past(internal_reset_o)
        |-> recirculation_switch_one_o == ~stepper_high_side_switch_o
        && recirculation_switch_two_o == ~stepper_high_side_switch_o)
        else $error("Recirculation wrong");
    a_sync_single: assert property (
        sync_clock_first_o |-> !sync_clock_second_o ##1 !sync_clock_first_o)
        else $error("Sync pulse shape");
    a_sync_sets_a: assert property (
        sync_clock_first_o && !internal_reset_o |-> ##[1:2] stepper_high_side_switch_o[0])
        else $error("Sync A no set");
    a_sync_sets_b: assert property (
        sync_clock_second_o && !internal_reset_o |-> ##[1:2] stepper_high_side_switch_o[1])
        else $error("Sync B no set");
    a_duty_exclusive: assert property (
        !(duty_select_voltage_o && low_duty_indicator_oe_o) && !low_duty_indicator_o)
        else $error("Duty indicator wrong");
    a_leg_no_shoot: assert property (
        !(bridge_out1_o.high_on && bridge_out1_o.low_on)
        && !(bridge_out2_o.high_on && bridge_out2_o.low_on))
        else $error("Bridge leg shoot-through");
    a_lockout_on_sync: assert property (
        sync_clock_first_o || sync_clock_second_o |-> ##[0:3] lockout_o)
        else $error("No blanking after sync");
    a_lockout_holds: assert property (
        $rose(lockout_o) |-> lockout_o[*4])
        else $error("Blanking short");
endmodule

`default_nettype wire

/* smcl_top.sv */
// Serial command shift register, four command latches and drive decode
`default_nettype none

module smcl_top #(
    parameter int WORD_W = smcl_pkg::WORD_W,
    parameter int LOCKOUT_CYC = smcl_pkg::LOCKOUT_CYC
) (
    input wire logic clk_i,                            // System clock, 100 MHz
    input wire logic reset_i,                          // Synchronous reset, active high
    input wire logic serial_clock_i,                   // Serial clock from the host
    input wire logic serial_data_in_i,                 // Serial data, MSB first
    input wire logic load_strobe_i,                    // Load strobe, loads on fall
    input wire logic osc_reset_low_i,                  // High while reset pin is below 1 V
    input wire logic power_transition_i,               // High during power up or down
    input wire logic osc_discharge_i,                  // High during oscillator discharge
    input wire logic sense_trip_a_i,                   // Current comparator, channel A
    input wire logic sense_trip_b_i,                   // Current comparator, channel B
    input wire logic bridge_pwm_on_i,                  // Bridge PWM comparator, high in on time
    output logic [3:0] stepper_a_out_enable_o,         // Channel A low sides 1..4
    output logic [3:0] stepper_b_out_enable_o,         // Channel B low sides 1..4
    output logic [1:0] stepper_high_side_switch_o,     // High side per channel (A=0)
    output logic [1:0] recirculation_switch_one_o,     // Recirculation switch one per channel
    output logic [1:0] recirculation_switch_two_o,     // Recirculation switch two per channel
    output logic [1:0] current_ref_a_o,                // Reference code channel A
    output logic [1:0] current_ref_b_o,                // Reference code channel B
    output logic [9:0] current_ref_a_mv_o,             // Reference channel A in mV
    output logic [9:0] current_ref_b_mv_o,             // Reference channel B in mV
    output smcl_pkg::smcl_leg_t bridge_out1_o,         // Bridge leg one drive
    output smcl_pkg::smcl_leg_t bridge_out2_o,         // Bridge leg two drive
    output logic duty_select_voltage_o,                // 1 = high duty level chosen
    output logic low_duty_indicator_o,                 // Open-drain data, always low
    output logic low_duty_indicator_oe_o,              // Pull-down enable
    output logic sync_clock_first_o,                   // Sync pulse, channel A
    output logic sync_clock_second_o,                  // Sync pulse, channel B
    output logic lockout_o,                            // Comparator blanking active
    output logic internal_reset_o                      // Internal reset active
);

    localparam int CW = $clog2(LOCKOUT_CYC + 1);
    localparam logic [CW-1:0] LOCK_LOAD = CW'(LOCKOUT_CYC);
    localparam logic [CW-1:0] LOCK_ZERO = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Decode functions

    // Low-side enables for one stepper phase latch
    function automatic logic [3:0] phase_decode(input logic [3:0] lat);
        logic conflict;
        conflict = (lat[0] & lat[1]) | (lat[2] & lat[3]);
        phase_decode = conflict ? 4'h0 : lat;
    endfunction

    // Gate drive of one leg from its state and the PWM comparator
    function automatic smcl_pkg::smcl_leg_t leg_drive(input smcl_pkg::smcl_leg_state_t st,
                                                      input logic pwm_on);
        smcl_pkg::smcl_leg_t d;
        d = '0;
        case (st)
            smcl_pkg::LEG_SUPPLY: begin
                d.high_on = 1'b1;
            end
            smcl_pkg::LEG_GROUND: begin
                d.low_on = 1'b1;
            end
            smcl_pkg::LEG_CHOP: begin
                d.low_on = pwm_on;
                d.high_on = ~pwm_on;
            end
            default: begin
                d = '0;
            end
        endcase
        leg_drive = d;
    endfunction

    // Reference in millivolts for a two-bit code
    function automatic logic [9:0] ref_mv(input logic [1:0] code);
        ref_mv = ({8'h00, code} + 10'h001) * smcl_pkg::REF_MV_STEP;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: shift register on the serial clock

    logic [WORD_W-1:0] shift_r;
    logic [2:0] clr_req_sync_r;
    logic clr_ack_r;
    logic clr_req_tog_r;

    always_ff @(posedge serial_clock_i) begin
        shift_r <= {shift_r[WORD_W-2:0], serial_data_in_i};
    end

    // Clear request toggle crosses in; the acknowledge follows it back
    always_ff @(posedge serial_clock_i) begin
        clr_req_sync_r <= {clr_req_sync_r[1:0], clr_req_tog_r};
        if (clr_req_sync_r[1] == clr_req_sync_r[2]) begin
            clr_ack_r <= clr_req_sync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts once two and three agree

    logic [smcl_pkg::PIN_N-1:0] pin_raw;
    logic [smcl_pkg::PIN_N-1:0] pin_s1_r;
    logic [smcl_pkg::PIN_N-1:0] pin_s2_r;
    logic [smcl_pkg::PIN_N-1:0] pin_s3_r;
    logic [smcl_pkg::PIN_N-1:0] pin_f_r;
    logic [smcl_pkg::PIN_N-1:0] pin_f_nxt;
    logic [smcl_pkg::PIN_N-1:0] pin_prev_r;

    always_comb begin
        pin_raw = '0;
        pin_raw[smcl_pkg::PIN_STROBE] = load_strobe_i;
        pin_raw[smcl_pkg::PIN_OSC_RST] = osc_reset_low_i;
        pin_raw[smcl_pkg::PIN_POWER] = power_transition_i;
        pin_raw[smcl_pkg::PIN_DISCH] = osc_discharge_i;
        pin_raw[smcl_pkg::PIN_TRIP_A] = sense_trip_a_i;
        pin_raw[smcl_pkg::PIN_TRIP_B] = sense_trip_b_i;
        pin_raw[smcl_pkg::PIN_PWM] = bridge_pwm_on_i;
        pin_raw[smcl_pkg::PIN_ACK] = clr_ack_r;
    end

    assign pin_f_nxt = (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));

    always_ff @(posedge clk_i) begin
        pin_s1_r <= pin_raw;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        if (reset_i) begin
            pin_f_r <= '0;
            pin_prev_r <= '0;
        end else begin
            pin_f_r <= pin_f_nxt;
            pin_prev_r <= pin_f_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset

    logic int_rst;
    assign int_rst = reset_i
                   | pin_f_r[smcl_pkg::PIN_OSC_RST]
                   | pin_f_r[smcl_pkg::PIN_POWER];

    // While a clear is outstanding the shift register reads as zero
    logic clr_pend;
    assign clr_pend = clr_req_tog_r != pin_f_r[smcl_pkg::PIN_ACK];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clr_req_tog_r <= 1'b0;
        end else if (int_rst && !clr_pend) begin
            clr_req_tog_r <= ~clr_req_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command latches

    logic strobe_fall;
    logic [WORD_W-1:0] word_view;
    logic [smcl_pkg::LATCH_W-1:0] latch_r [smcl_pkg::LATCH_N];

    assign strobe_fall = pin_prev_r[smcl_pkg::PIN_STROBE] & ~pin_f_r[smcl_pkg::PIN_STROBE];
    // Shift register is still when the strobe falls, so it is sampled as a quiet bus
    assign word_view = clr_pend ? '0 : shift_r;

    for (genvar i = 0; i < smcl_pkg::LATCH_N; i++) begin : g_latch
        always_ff @(posedge clk_i) begin
            if (int_rst) begin
                latch_r[i] <= '0;
            end else if (strobe_fall) begin
                latch_r[i] <= word_view[i*smcl_pkg::LATCH_W +: smcl_pkg::LATCH_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator sync clocks and lockout window

    logic disch_rise;
    logic sync_sel_r;
    logic [1:0] sync_pulse_r;
    logic [CW-1:0] lock_cnt_r;
    logic lockout;

    assign disch_rise = pin_f_r[smcl_pkg::PIN_DISCH] & ~pin_prev_r[smcl_pkg::PIN_DISCH];
    assign lockout = pin_f_r[smcl_pkg::PIN_DISCH] | (lock_cnt_r != LOCK_ZERO);

    // Alternate discharges feed the two channels, half the oscillator rate each
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            sync_sel_r <= 1'b0;
            sync_pulse_r <= 2'h0;
        end else begin
            sync_pulse_r <= 2'h0;
            if (disch_rise) begin
                sync_sel_r <= ~sync_sel_r;
                sync_pulse_r <= sync_sel_r ? 2'h2 : 2'h1;
            end
        end
    end

    // Lockout lasts at least its nominal time past the discharge start
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            lock_cnt_r <= LOCK_ZERO;
        end else if (disch_rise) begin
            lock_cnt_r <= LOCK_LOAD;
        end else if (lock_cnt_r != LOCK_ZERO) begin
            lock_cnt_r <= lock_cnt_r - CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stepper chopping flops

    logic [1:0] chop_r;
    logic [1:0] trip;

    assign trip = {pin_f_r[smcl_pkg::PIN_TRIP_B], pin_f_r[smcl_pkg::PIN_TRIP_A]};

    for (genvar c = 0; c < 2; c++) begin : g_chop
        always_ff @(posedge clk_i) begin
            if (int_rst) begin
                chop_r[c] <= 1'b0;
            end else if (sync_pulse_r[c]) begin
                chop_r[c] <= 1'b1;
            end else if (trip[c] && !lockout) begin
                chop_r[c] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bridge leg states

    logic [smcl_pkg::LATCH_W-1:0] br;
    logic [1:0] br_in;
    smcl_pkg::smcl_leg_state_t leg1_st;
    smcl_pkg::smcl_leg_state_t leg2_st;

    assign br = latch_r[smcl_pkg::LAT_BRIDGE];
    assign br_in = {br[smcl_pkg::BR_IN2], br[smcl_pkg::BR_IN1]};

    always_comb begin
        leg1_st = smcl_pkg::LEG_OFF;
        leg2_st = smcl_pkg::LEG_OFF;
        if (br[smcl_pkg::BR_DUTY_LO] && br[smcl_pkg::BR_DUTY_HI]) begin
            case (br_in)
                2'h1: begin
                    leg1_st = smcl_pkg::LEG_SUPPLY;
                    leg2_st = smcl_pkg::LEG_GROUND;
                end
                2'h2: begin
                    leg1_st = smcl_pkg::LEG_GROUND;
                    leg2_st = smcl_pkg::LEG_SUPPLY;
                end
                2'h3: begin
                    leg1_st = smcl_pkg::LEG_GROUND;
                    leg2_st = smcl_pkg::LEG_GROUND;
                end
                default: begin
                    leg1_st = smcl_pkg::LEG_OFF;
                    leg2_st = smcl_pkg::LEG_OFF;
                end
            endcase
        end else if (br[smcl_pkg::BR_DUTY_LO] || br[smcl_pkg::BR_DUTY_HI]) begin
            case (br_in)
                2'h1: begin
                    leg1_st = smcl_pkg::LEG_SUPPLY;
                    leg2_st = smcl_pkg::LEG_CHOP;
                end
                2'h2: begin
                    leg1_st = smcl_pkg::LEG_CHOP;
                    leg2_st = smcl_pkg::LEG_SUPPLY;
                end
                2'h3: begin
                    leg1_st = smcl_pkg::LEG_SUPPLY;
                    leg2_st = smcl_pkg::LEG_SUPPLY;
                end
                default: begin
                    leg1_st = smcl_pkg::LEG_OFF;
                    leg2_st = smcl_pkg::LEG_OFF;
                end
            endcase
        end else begin
            leg1_st = smcl_pkg::LEG_OFF;
            leg2_st = smcl_pkg::LEG_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic [1:0] ref_a;
    logic [1:0] ref_b;
    logic duty_lo_sel;
    logic duty_hi_sel;

    assign ref_a = latch_r[smcl_pkg::LAT_REF][smcl_pkg::REF_A_LSB +: 2];
    assign ref_b = latch_r[smcl_pkg::LAT_REF][smcl_pkg::REF_B_LSB +: 2];
    assign duty_lo_sel = br[smcl_pkg::BR_DUTY_LO] & ~br[smcl_pkg::BR_DUTY_HI];
    assign duty_hi_sel = br[smcl_pkg::BR_DUTY_HI] & ~br[smcl_pkg::BR_DUTY_LO];

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            stepper_a_out_enable_o <= 4'h0;
            stepper_b_out_enable_o <= 4'h0;
        end else begin
            stepper_a_out_enable_o <= phase_decode(latch_r[smcl_pkg::LAT_PHASE_A]);
            stepper_b_out_enable_o <= phase_decode(latch_r[smcl_pkg::LAT_PHASE_B]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            stepper_high_side_switch_o <= 2'h0;
            recirculation_switch_one_o <= 2'h0;
            recirculation_switch_two_o <= 2'h0;
        end else begin
            stepper_high_side_switch_o <= chop_r;
            recirculation_switch_one_o <= ~chop_r;
            recirculation_switch_two_o <= ~chop_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            current_ref_a_o <= 2'h0;
            current_ref_b_o <= 2'h0;
            current_ref_a_mv_o <= ref_mv(2'h0);
            current_ref_b_mv_o <= ref_mv(2'h0);
        end else begin
            current_ref_a_o <= ref_a;
            current_ref_b_o <= ref_b;
            current_ref_a_mv_o <= ref_mv(ref_a);
            current_ref_b_mv_o <= ref_mv(ref_b);
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            bridge_out1_o <= '0;
            bridge_out2_o <= '0;
            duty_select_voltage_o <= 1'b0;
            low_duty_indicator_oe_o <= 1'b0;
        end else begin
            bridge_out1_o <= leg_drive(leg1_st, pin_f_r[smcl_pkg::PIN_PWM]);
            bridge_out2_o <= leg_drive(leg2_st, pin_f_r[smcl_pkg::PIN_PWM]);
            duty_select_voltage_o <= duty_hi_sel;
            low_duty_indicator_oe_o <= duty_lo_sel;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lockout_o <= 1'b0;
            internal_reset_o <= 1'b1;
        end else begin
            lockout_o <= lockout;
            internal_reset_o <= int_rst;
        end
    end

    // Open-drain pin only ever pulls low
    assign low_duty_indicator_o = 1'b0;
    assign sync_clock_first_o = sync_pulse_r[0];
    assign sync_clock_second_o = sync_pulse_r[1];

endmodule

`default_nettype wire

/* smcl_top_tb.sv */
// Testbench for the command latch block
`default_nettype none

module smcl_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic reset_i = 1'b1;
    logic osc_reset_low_i = 1'b0;
    logic power_transition_i = 1'b0;
    logic osc_discharge_i = 1'b0;
    logic sense_trip_a_i = 1'b0;
    logic sense_trip_b_i = 1'b0;
    logic bridge_pwm_on_i = 1'b0;
    wire logic serial_clock_i, serial_data_in_i, load_strobe_i;
    logic [3:0] stepper_a_out_enable_o, stepper_b_out_enable_o;
    logic [1:0] stepper_high_side_switch_o, recirculation_switch_one_o;
    logic [1:0] recirculation_switch_two_o, current_ref_a_o, current_ref_b_o;
    logic [9:0] current_ref_a_mv_o, current_ref_b_mv_o;
    smcl_pkg::smcl_leg_t bridge_out1_o, bridge_out2_o;
    logic duty_select_voltage_o, low_duty_indicator_o, low_duty_indicator_oe_o;
    logic sync_clock_first_o, sync_clock_second_o, lockout_o, internal_reset_o;
    int err_total = 0;
    int cmp_count = 0;
    int first_cnt = 0;
    int second_cnt = 0;

    always #5 clk_i = ~clk_i;
    initial #3 forever #7.5 link_clk = ~link_clk;

    smcl_top #(.LOCKOUT_CYC(4)) u_dut (
        .clk_i, .reset_i, .serial_clock_i, .serial_data_in_i, .load_strobe_i,
        .osc_reset_low_i, .power_transition_i, .osc_discharge_i, .sense_trip_a_i,
        .sense_trip_b_i, .bridge_pwm_on_i, .stepper_a_out_enable_o,
        .stepper_b_out_enable_o, .stepper_high_side_switch_o, .recirculation_switch_one_o,
        .recirculation_switch_two_o, .current_ref_a_o, .current_ref_b_o,
        .current_ref_a_mv_o, .current_ref_b_mv_o, .bridge_out1_o, .bridge_out2_o,
        .duty_select_voltage_o, .low_duty_indicator_o, .low_duty_indicator_oe_o,
        .sync_clock_first_o, .sync_clock_second_o, .lockout_o, .internal_reset_o);

    smcl_host u_host (.link_clk_i(link_clk), .serial_clock_o(serial_clock_i),
        .serial_data_o(serial_data_in_i), .load_strobe_o(load_strobe_i));

    always @(posedge clk_i) begin
        if (sync_clock_first_o === 1'b1) first_cnt++;
        if (sync_clock_second_o === 1'b1) second_cnt++;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [3:0] ph(input logic [3:0] n);
        return ((n[0] & n[1]) | (n[2] & n[3])) ? 4'h0 : n;
    endfunction

    // Expected {leg1, leg2}, each {high_on, low_on}
    function automatic logic [3:0] br(input logic [3:0] n, input logic pwm);
        logic [1:0] chop;
        chop = pwm ? 2'h1 : 2'h2;
        if (n[3:2] == 2'h0 || n[1:0] == 2'h0) return 4'h0;
        if (n[3:2] == 2'h3) begin
            case (n[1:0])
                2'h1: return 4'h9;
                2'h2: return 4'h6;
                default: return 4'h5;
            endcase
        end
        case (n[1:0])
            2'h1: return {2'h2, chop};
            2'h2: return {chop, 2'h2};
            default: return 4'hA;
        endcase
    endfunction

    // Nibbles differ, save phases A and B for n of 6 and 14, to expose misrouted fields
    task automatic load_check(input logic [3:0] n);
        logic [15:0] w;
        logic pwm;
        w = {n, n ^ 4'h6, ~n, n + 4'h3};
        pwm = n[0] ^ n[3];
        @(posedge clk_i);
        bridge_pwm_on_i <= pwm;
        u_host.send_word(w);
        repeat (12) @(posedge clk_i);
        check(stepper_a_out_enable_o, ph(w[3:0]));
        check(stepper_b_out_enable_o, ph(w[7:4]));
        check({current_ref_b_o, current_ref_a_o}, w[11:8]);
        check(current_ref_a_mv_o, (16'(w[9:8]) + 16'h0001) * 16'h007D);
        check(current_ref_b_mv_o, (16'(w[11:10]) + 16'h0001) * 16'h007D);
        check({bridge_out1_o, bridge_out2_o}, br(w[15:12], pwm));
        check({duty_select_voltage_o, low_duty_indicator_oe_o, low_duty_indicator_o},
            {w[15] & ~w[14], w[14] & ~w[15], 1'b0});
    endtask

    task automatic pin_reset(input logic pwr);
        load_check(4'h5);
        @(posedge clk_i);
        if (pwr) power_transition_i <= 1'b1;
        else osc_reset_low_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({internal_reset_o, stepper_a_out_enable_o, bridge_out1_o, bridge_out2_o},
            {1'b1, 8'h00});
        check(current_ref_a_mv_o, 16'h007D);
        osc_reset_low_i <= 1'b0;
        power_transition_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check({internal_reset_o, stepper_a_out_enable_o, current_ref_a_o}, 16'h0000);
    endtask

    task automatic discharge(input logic trip);
        @(posedge clk_i);
        osc_discharge_i <= 1'b1;
        sense_trip_a_i <= trip;
        repeat (4) @(posedge clk_i);
        osc_discharge_i <= 1'b0;
        sense_trip_a_i <= 1'b0;
        repeat (20) @(posedge clk_i);
    endtask

    task automatic trip_pulse(input logic chan_b);
        @(posedge clk_i);
        if (chan_b) sense_trip_b_i <= 1'b1;
        else sense_trip_a_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        sense_trip_a_i <= 1'b0;
        sense_trip_b_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({internal_reset_o, stepper_b_out_enable_o, current_ref_b_mv_o},
            {1'b0, 4'h0, 10'h07D});
        for (int i = 0; i < 16; i++) load_check(4'(i));
        pin_reset(1'b0);
        pin_reset(1'b1);
        discharge(1'b0);
        check({8'(first_cnt), 8'(second_cnt)}, 16'h0100);
        check({stepper_high_side_switch_o, recirculation_switch_one_o}, 4'h6);
        trip_pulse(1'b0);
        check({stepper_high_side_switch_o, recirculation_switch_two_o}, 4'h3);
        discharge(1'b0);
        check(16'(second_cnt), 16'h0001);
        check(stepper_high_side_switch_o, 16'h0002);
        discharge(1'b1);
        check(16'(first_cnt), 16'h0002);
        check(stepper_high_side_switch_o, 16'h0003);
        trip_pulse(1'b1);
        check({stepper_high_side_switch_o, recirculation_switch_one_o}, 4'h6);
        final_report;
    end

    initial begin
        #500000;
        err_total++;
        final_report;
    end
endmodule

bind smcl_top smcl_props u_props (
    .clk_i, .reset_i, .stepper_a_out_enable_o, .stepper_b_out_enable_o,
    .stepper_high_side_switch_o, .recirculation_switch_one_o, .recirculation_switch_two_o,
    .current_ref_a_o, .current_ref_b_o, .current_ref_a_mv_o, .current_ref_b_mv_o,
    .bridge_out1_o, .bridge_out2_o, .duty_select_voltage_o, .low_duty_indicator_o,
    .low_duty_indicator_oe_o, .sync_clock_first_o, .sync_clock_second_o, .lockout_o,
    .internal_reset_o);

`default_nettype wire
